// *** fic_pkg.sv ***
// shared constants and types for the flash identification host controller
`default_nettype none
package fic_pkg;
   // ==========================================================
   // instruction codes
   localparam logic [7:0] OP_ID = 8'h90;
   localparam logic [7:0] OP_ID2 = 8'h92;
   localparam logic [7:0] OP_ID4 = 8'h94;
   localparam logic [7:0] OP_UID = 8'h4B;
   localparam logic [7:0] OP_JID = 8'h9F;
   localparam logic [7:0] OP_PTAB = 8'h5A;
   localparam logic [7:0] OP_SERASE = 8'h44;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] MODE_BITS = 8'hF0;
   // ==========================================================
   // register map of the controller
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ADDR_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] RXLO_OFS = 8'h0C;
   localparam logic [7:0] RXHI_OFS = 8'h10;
   localparam int CTRL_NB_LSB = 8;
   localparam int CTRL_POLL_BIT = 12;
   localparam int CTRL_START_BIT = 31;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int SR_BUSY_BIT = 0;
   localparam int SR_WEL_BIT = 1;
   // ==========================================================
   // frame shape: lengths in link clocks, address and mode in bits
   localparam logic [6:0] CMD_CLKS = 7'h08;
   localparam logic [6:0] ADDR_BITS = 7'h18;
   localparam logic [6:0] MODE_LEN = 7'h08;
   localparam logic [6:0] QUAD_PRE_CLKS = 7'h04;
   localparam logic [6:0] UID_DUMMY_CLKS = 7'h20;
   localparam logic [6:0] PTAB_DUMMY_CLKS = 7'h08;
   // ==========================================================
   // timing
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int SCK_HZ = 2_500_000;
   localparam int SCK_HALF_CYC = SYS_CLK_HZ / (2 * SCK_HZ);
   // ==========================================================
   // types
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01, ST_CMD = 8'h02, ST_PRE = 8'h04, ST_ADDR = 8'h08,
      ST_MODE = 8'h10, ST_DUMMY = 8'h20, ST_READ = 8'h40, ST_END = 8'h80
   } fic_state_e;
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } fic_pins_s;
   typedef struct packed {
      logic [1:0] sh;
      logic [6:0] pre;
      logic [6:0] addr;
      logic [6:0] mode;
      logic [6:0] dummy;
   } fic_fmt_s;
endpackage : fic_pkg
`default_nettype wire

// *** fic_host.sv ***
// host controller issuing identification reads and security erase
// Overview of operation
// - 90h sends zero address, reads two bytes
// - 92h address and answer two bits/clock
// - dual/quad id reads send mode Fxh
// - 94h four dummies, address four bits/clock
// - 4Bh four dummy bytes, 64-bit id
// - 5Ah address, eight dummies, data at 40
// - table read keeps upper sixteen bits zero
// - erase address selects register one-three
// - select rises right after last address bit
// - select rise ends each identification read
`timescale 1ns/1ns
`default_nettype none
module fic_host #(
   parameter int HALF_CYC = fic_pkg::SCK_HALF_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_spi_cs_n,
   output logic o_spi_sck,
   output var fic_pkg::fic_pins_s o_io_pins,
   input wire logic [3:0] i_io_in
);
   import fic_pkg::*;

   // ==========================================================
   // state
   fic_state_e st_r, st_nxt;
   logic [7:0] op_r, cur_op_r;
   logic [23:0] addr_r;
   logic [3:0] nb_r, cur_nb_r;
   logic poll_r, polling_r, repoll_r, start_pend_r;
   logic busy_r, done_r;
   logic [7:0] sr_r;
   logic [63:0] rx_r, rx_nxt;
   logic [39:0] tx_r, tx_nxt;
   logic [6:0] cnt_r, cnt_nxt, rise_cnt_r, n_rd;
   logic [7:0] half_r;
   logic sck_r, sck_nxt, cs_n_r, cs_nxt;
   logic [3:0] sync1_r, sync2_r;
   fic_pins_s pins_r;
   logic [31:0] rdata_r;
   fic_fmt_s f;
   logic tick, launch, end_evt, rise, repoll_cond;

   // ==========================================================
   // per-instruction frame shape
   function automatic fic_fmt_s fmt_of(input logic [7:0] op);
      fic_fmt_s r;
      r = '0;
      case (op)
         OP_ID: r.addr = ADDR_BITS;
         OP_ID2: begin
            r.sh = 2'd1;
            r.addr = ADDR_BITS >> 1;
            r.mode = MODE_LEN >> 1;
         end
         OP_ID4: begin
            r.sh = 2'd2;
            r.pre = QUAD_PRE_CLKS;
            r.addr = ADDR_BITS >> 2;
            r.mode = MODE_LEN >> 2;
         end
         OP_UID: r.dummy = UID_DUMMY_CLKS;
         OP_PTAB: begin
            r.addr = ADDR_BITS;
            r.dummy = PTAB_DUMMY_CLKS;
         end
         OP_SERASE: r.addr = ADDR_BITS;
         default: r.addr = '0;
      endcase
      return r;
   endfunction : fmt_of

   // address forced into its legal shape per instruction
   function automatic logic [23:0] fix_addr(input logic [7:0] op,
                                           input logic [23:0] a);
      logic [23:0] r;
      r = a;
      if (op == OP_ID) begin
         r = '0;
      end else if (op == OP_PTAB) begin
         r = {16'h0000, a[7:0]};
      end else if (op == OP_SERASE) begin
         r = {8'h00, a[15:12], 4'h0, a[7:0]};
      end
      return r;
   endfunction : fix_addr

   // next phase with a non-zero length; a frame with none left ends
   function automatic fic_state_e step(input fic_state_e s,
                                       input fic_fmt_s g,
                                       input logic [6:0] nr);
      fic_state_e r;
      r = ST_END;
      if (s == ST_CMD && g.pre != '0) begin
         r = ST_PRE;
      end else if (s inside {ST_CMD, ST_PRE} && g.addr != '0) begin
         r = ST_ADDR;
      end else if (s inside {ST_CMD, ST_PRE, ST_ADDR} && g.mode != '0) begin
         r = ST_MODE;
      end else if (s inside {ST_CMD, ST_PRE, ST_ADDR, ST_MODE}
                   && g.dummy != '0) begin
         r = ST_DUMMY;
      end else if (s != ST_READ && nr != '0) begin
         r = ST_READ;
      end
      return r;
   endfunction : step

   function automatic logic [6:0] len_of(input fic_state_e s,
                                         input fic_fmt_s g,
                                         input logic [6:0] nr);
      logic [6:0] r;
      case (s)
         ST_PRE: r = g.pre;
         ST_ADDR: r = g.addr;
         ST_MODE: r = g.mode;
         ST_DUMMY: r = g.dummy;
         ST_READ: r = nr;
         default: r = '0;
      endcase
      return r;
   endfunction : len_of

   // lane use; hold and protect lines are driven high when not data
   function automatic fic_pins_s pins_of(input fic_state_e s,
                                         input logic [1:0] sh,
                                         input logic [39:0] t);
      fic_pins_s r;
      logic [1:0] w;
      w = (s inside {ST_ADDR, ST_MODE, ST_READ}) ? sh : 2'd0;
      r.out = 4'hC;
      r.oe = 4'hD;
      if (s == ST_READ) begin
         r.oe = (w == 2'd0) ? 4'hD : (w == 2'd1) ? 4'hC : 4'h0;
      end else if (s inside {ST_IDLE, ST_END, ST_PRE, ST_DUMMY}) begin
         r.out = 4'hC;
      end else if (w == 2'd0) begin
         r.out = {3'b110, t[39]};
      end else if (w == 2'd1) begin
         r.out = {2'b11, t[39:38]};
         r.oe = 4'hF;
      end else begin
         r.out = t[39:36];
         r.oe = 4'hF;
      end
      return r;
   endfunction : pins_of

   assign f = fmt_of(cur_op_r);
   assign n_rd = 7'({cur_nb_r, 3'b000} >> f.sh);
   assign tick = (half_r == '0);
   assign launch = (st_r == ST_IDLE) && (start_pend_r || repoll_r);
   assign end_evt = (st_r == ST_END) && tick;
   assign rise = tick && !sck_r && !(st_r inside {ST_IDLE, ST_END});
   // with polling on, erase done on the host side only once busy reads back clear
   assign repoll_cond = poll_r && ((cur_op_r == OP_SERASE)
      || (polling_r && rx_r[SR_BUSY_BIT]));

   // ==========================================================
   // link sequencing: data changes on falls, samples on rises
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      sck_nxt = sck_r;
      cs_nxt = cs_n_r;
      case (st_r)
         ST_IDLE: begin
            if (launch) begin
               st_nxt = ST_CMD;
               cnt_nxt = CMD_CLKS;
               tx_nxt = {repoll_r ? OP_RDSR : op_r,
                         fix_addr(op_r, addr_r), MODE_BITS};
               rx_nxt = '0;
               cs_nxt = 1'b0;
            end
         end
         ST_END: begin
            if (tick) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            if (tick && !sck_r) begin
               sck_nxt = 1'b1;
               cnt_nxt = cnt_r - 7'd1;
               if (st_r == ST_READ) begin
                  // device shifts on falls; we take it on rises
                  case (f.sh)
                     2'd0: rx_nxt = {rx_r[62:0], sync2_r[1]};
                     2'd1: rx_nxt = {rx_r[61:0], sync2_r[1:0]};
                     default: rx_nxt = {rx_r[59:0], sync2_r};
                  endcase
               end
            end else if (tick) begin
               sck_nxt = 1'b0;
               if (st_r == ST_CMD) begin
                  tx_nxt = tx_r << 1;
               end else if (st_r inside {ST_ADDR, ST_MODE}) begin
                  tx_nxt = tx_r << (3'd1 << f.sh);
               end
               if (cnt_r == '0) begin
                  st_nxt = step(st_r, f, n_rd);
                  cnt_nxt = len_of(st_nxt, f, n_rd);
                  // select rises right after the last bit
                  cs_nxt = (st_nxt == ST_END);
               end
            end
         end
      endcase
   end

   // half-period divider, restarted at launch for full setup time
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         half_r <= '0;
      end else if (tick || launch) begin
         half_r <= 8'(HALF_CYC - 1);
      end else begin
         half_r <= half_r - 8'd1;
      end
   end

   // link registers and pins
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st_r <= ST_IDLE;
         cnt_r <= '0;
         tx_r <= '0;
         rx_r <= '0;
         sck_r <= 1'b0;
         cs_n_r <= 1'b1;
         pins_r <= '{out: 4'hC, oe: 4'hD};
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         sck_r <= sck_nxt;
         cs_n_r <= cs_nxt;
         pins_r <= pins_of(st_nxt, f.sh, tx_nxt);
      end
   end

   // two-stage capture of the io pins
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= i_io_in;
         sync2_r <= sync1_r;
      end
   end

   // ==========================================================
   // command bookkeeping and erase polling
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cur_op_r <= OP_RDSR;
         cur_nb_r <= '0;
         polling_r <= 1'b0;
         repoll_r <= 1'b0;
         start_pend_r <= 1'b0;
         busy_r <= 1'b0;
         sr_r <= '0;
      end else begin
         if (launch) begin
            cur_op_r <= repoll_r ? OP_RDSR : op_r;
            cur_nb_r <= repoll_r ? 4'd1 : nb_r;
            polling_r <= repoll_r;
            repoll_r <= 1'b0;
            start_pend_r <= 1'b0;
         end else if (end_evt) begin
            repoll_r <= repoll_cond;
            busy_r <= repoll_cond;
         end else if (i_wr && i_addr == CTRL_OFS && i_wdata[CTRL_START_BIT]
                      && !busy_r) begin
            start_pend_r <= 1'b1;
            busy_r <= 1'b1;
         end
         // last status byte: write latch and busy bits show here
         if (end_evt && cur_op_r == OP_RDSR) begin
            sr_r <= rx_r[7:0];
         end
      end
   end

   // completion flag; a completion beats a clearing read
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         done_r <= 1'b0;
      end else if (end_evt && !repoll_cond) begin
         done_r <= 1'b1;
      end else if (i_rd && i_addr == STAT_OFS) begin
         done_r <= 1'b0;
      end
   end

   // ==========================================================
   // register port
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         op_r <= OP_JID;
         addr_r <= '0;
         nb_r <= 4'd3;
         poll_r <= 1'b0;
      end else if (i_wr && i_addr == CTRL_OFS && !busy_r) begin
         op_r <= i_wdata[7:0];
         nb_r <= i_wdata[CTRL_NB_LSB +: 4]; // more bytes alternate
         poll_r <= i_wdata[CTRL_POLL_BIT];
      end else if (i_wr && i_addr == ADDR_OFS && !busy_r) begin
         addr_r <= i_wdata[23:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rdata_r <= '0;
      end else if (i_rd && i_addr == CTRL_OFS) begin
         rdata_r <= {19'h0, poll_r, nb_r, op_r};
      end else if (i_rd && i_addr == ADDR_OFS) begin
         rdata_r <= {8'h00, addr_r};
      end else if (i_rd && i_addr == STAT_OFS) begin
         rdata_r <= {16'h0000, sr_r, 6'h00, done_r, busy_r};
      end else if (i_rd && i_addr == RXLO_OFS) begin
         rdata_r <= rx_r[31:0];
      end else if (i_rd && i_addr == RXHI_OFS) begin
         rdata_r <= rx_r[63:32];
      end else begin
         rdata_r <= '0;
      end
   end

   // rising clocks seen in the current frame, for checking only
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || cs_n_r) begin
         rise_cnt_r <= '0;
      end else if (rise) begin
         rise_cnt_r <= rise_cnt_r + 7'd1;
      end
   end

   assign o_rdata = rdata_r;
   assign o_spi_cs_n = cs_n_r;
   assign o_spi_sck = sck_r;
   assign o_io_pins = pins_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   id_zero_addr_a: assert property (
      st_r == ST_ADDR && cur_op_r == OP_ID |-> !pins_r.out[0])
      else $error("nonzero address bit on 90h");
   mode_bits_a: assert property (
      $rose(st_r == ST_MODE) |-> pins_r.out[1:0] == 2'b11)
      else $error("mode bits not Fxh");
   dual_turn_a: assert property (
      $rose(st_r == ST_READ) && cur_op_r == OP_ID2 |-> rise_cnt_r == 7'd24)
      else $error("92h answer at wrong clock");
   quad_turn_a: assert property (
      $rose(st_r == ST_READ) && cur_op_r == OP_ID4 |-> rise_cnt_r == 7'd20)
      else $error("94h answer at wrong clock");
   uid_turn_a: assert property (
      $rose(st_r == ST_READ) && cur_op_r == OP_UID |-> rise_cnt_r == 7'd40)
      else $error("4Bh answer at wrong clock");
   jid_turn_a: assert property (
      $rose(st_r == ST_READ) && cur_op_r == OP_JID |-> rise_cnt_r == 7'd8)
      else $error("9Fh answer at wrong clock");
   ptab_turn_a: assert property (
      $rose(st_r == ST_READ) && cur_op_r == OP_PTAB |-> rise_cnt_r == 7'd40)
      else $error("5Ah answer at wrong clock");
   ptab_addr_a: assert property (
      $rose(st_r == ST_ADDR) && cur_op_r == OP_PTAB |-> tx_r[39:24] == '0)
      else $error("table address upper bits set");
   erase_addr_a: assert property (
      $rose(st_r == ST_ADDR) && cur_op_r == OP_SERASE
      |-> tx_r[39:32] == '0 && tx_r[27:24] == '0)
      else $error("erase address malformed");
   erase_len_a: assert property (
      $rose(cs_n_r) && cur_op_r == OP_SERASE |-> rise_cnt_r == 7'd32)
      else $error("erase frame not 32 clocks");
   erase_poll_a: assert property (
      $rose(cs_n_r) && cur_op_r == OP_SERASE && poll_r
      |-> ##[1:64] (repoll_r && busy_r))
      else $error("no status poll after erase");
   sck_idle_a: assert property (
      cs_n_r |-> !sck_r)
      else $error("clock moving while deselected");
endmodule : fic_host
`default_nettype wire

// *** fic_flash_model.sv ***
// behavioural model of the serial flash seen from the host controller
`timescale 1ns/1ns
`default_nettype none
module fic_flash_model #(
   // maker, memory type, capacity, device codes: arbitrary values
   parameter logic [63:0] IDS = 64'h3C61_16A7_0000_0000,
   parameter logic [63:0] UID = 64'h0123_4567_89AB_CDEF,
   parameter logic [2:0] LOCK = 3'h4,
   parameter int ERASE_NS = 20000
) (
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic [3:0] i_io,
   output logic [3:0] o_out,
   output logic [3:0] o_oe,
   output logic o_err,
   output int o_erases,
   output int o_polls
);
   int cnt = 0;
   int a0, a1, m1;
   int rs = 999;
   logic hit;
   logic [3:0] pre;
   logic [2:0] al, ml, rl;
   logic [5:0] dm;
   logic [7:0] op, md;
   logic [23:0] adr;
   logic [63:0] sr;
   logic busy = 1'h0;
   logic write_latch_flag = 1'h0;

   initial begin
      o_oe = 4'h0;
      o_out = 4'h0;
      o_err = 1'h0;
      o_erases = 0;
      o_polls = 0;
   end

   function automatic logic [3:0] msk(input int n);
      return n == 4 ? 4'hF : (n == 2 ? 4'h3 : 4'h1);
   endfunction : msk

   // frame shape: {answers, pre, addr lanes, mode lanes, dummy, out lanes}
   // the shape fields are 19 bits; a wider word would eat the answer flag
   task automatic setup();
      case (op)
         8'h90: {hit, pre, al, ml, dm, rl} =
            {1'h1, 4'h0, 3'h1, 3'h0, 6'h0, 3'h1};
         8'h92: {hit, pre, al, ml, dm, rl} =
            {1'h1, 4'h0, 3'h2, 3'h2, 6'h0, 3'h2};
         8'h94: {hit, pre, al, ml, dm, rl} =
            {1'h1, 4'h4, 3'h4, 3'h4, 6'h0, 3'h4};
         8'h4B: {hit, pre, al, ml, dm, rl} =
            {1'h1, 4'h0, 3'h0, 3'h0, 6'h20, 3'h1};
         8'h5A: {hit, pre, al, ml, dm, rl} =
            {1'h1, 4'h0, 3'h1, 3'h0, 6'h8, 3'h1};
         8'h44: {hit, pre, al, ml, dm, rl} =
            {1'h0, 4'h0, 3'h1, 3'h0, 6'h0, 3'h1};
         8'h9F, 8'h05: {hit, pre, al, ml, dm, rl} = {1'h1, 19'h1};
         default: {hit, pre, al, ml, dm, rl} = {1'h0, 19'h1};
      endcase
      a0 = 8 + pre;
      a1 = a0 + (al == 0 ? 0 : 24 / al);
      m1 = a1 + (ml == 0 ? 0 : 8 / ml);
      // only the status read is answered while an erase runs
      rs = (hit && (!busy || op == 8'h05)) ? m1 + dm : 999;
   endtask : setup

   // answer word chosen once the last address, mode or dummy clock is in
   task automatic load();
      case (op)
         8'h90, 8'h92, 8'h94: begin
            sr = adr[0] ? {4{IDS[39:32], IDS[63:56]}}
               : {4{IDS[63:56], IDS[39:32]}};
            if (adr > 24'h1 || (op == 8'h90 && adr != 24'h0))
               o_err = 1'h1;
            if (op != 8'h90 && md[7:4] != 4'hF) o_err = 1'h1;
         end
         8'h4B: sr = UID;
         8'h9F: sr = IDS;
         8'h5A: begin
            if (adr[23:8] != 16'h0) o_err = 1'h1;
            for (int i = 0; i < 8; i++)
               sr[63-8*i -: 8] = (adr[7:0] + 8'(i)) ^ 8'hA5;
         end
         default: begin
            sr = {8{6'h0, write_latch_flag, busy}};
            o_polls = o_polls + int'(busy);
         end
      endcase
   endtask : load

   // new frame forgets the previous instruction
   always @(negedge i_cs_n) begin
      cnt = 0;
      op = 8'h0;
      rs = 999;
   end

   // rising clock: opcode, address and mode bits come in
   always @(posedge i_sck) begin
      if (!i_cs_n) begin
         if (cnt < 8) begin
            op = {op[6:0], i_io[0]};
            if (cnt == 7) setup();
         end else if (cnt >= a0 && cnt < a1) begin
            adr = (adr << al) | 24'(i_io & msk(al));
         end else if (cnt >= a1 && cnt < m1) begin
            md = (md << ml) | 8'(i_io & msk(ml));
         end
         cnt++;
         if (cnt == rs) load();
      end
   end

   // falling clock: next answer bits, msb first on the upper lanes
   always @(negedge i_sck) begin
      if (!i_cs_n && cnt >= rs) begin
         o_oe = msk(rl) << (rl == 3'h1);
         o_out = (sr[63:60] >> (4 - rl)) << (rl == 3'h1);
         sr = sr << rl;
      end
   end

   // select rise ends the frame; erase is checked and started here
   always @(posedge i_cs_n) begin
      o_oe = 4'h0;
      if (op == 8'h06 && cnt == 8 && !busy) write_latch_flag = 1'h1;
      if (op == 8'h44 && (adr[23:16] != 8'h0 || adr[11:8] != 4'h0))
         o_err = 1'h1;
      if (op == 8'h44 && !busy && cnt == 32 && write_latch_flag &&
         adr[23:16] == 8'h0 && adr[11:8] == 4'h0 &&
         adr[15:12] inside {[1:3]} &&
         !LOCK[adr[15:12] - 4'h1]) begin
         busy = 1'h1;
         fork
            begin
               #(ERASE_NS);
               busy = 1'h0;
               write_latch_flag = 1'h0;
               o_erases++;
            end
         join_none
      end
   end
endmodule : fic_flash_model
`default_nettype wire

// *** fic_host_tb_top.sv ***
// self-checking bench: host controller against the flash model
`timescale 1ns/1ns
`default_nettype none
module fic_host_tb_top;
   import fic_pkg::*;
   // maker, type, capacity, device codes: arbitrary values
   localparam logic [63:0] IDS = 64'h3C61_16A7_0000_0000;
   localparam logic [63:0] UID = 64'h0123_4567_89AB_CDEF;
   logic i_sys_clk = 1'h0;
   logic i_rst_n = 1'h0;
   logic [7:0] i_addr = 8'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'h0;
   logic i_rd = 1'h0;
   logic [31:0] o_rdata;
   logic cs_n, sck, m_err;
   fic_pins_s pins;
   logic [3:0] lvl, m_out, m_oe;
   logic [3:0] flip = 4'h0;
   int m_erases, m_polls;
   int err_count = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'h5DA1C36C;
   logic [63:0] rx;
   logic [31:0] st;

   always #25 i_sys_clk = ~i_sys_clk;
   // released lines flip every cycle so no stale level is read back
   always @(posedge i_sys_clk) flip <= ~flip;
   assign lvl = (pins.oe & pins.out) | (~pins.oe & m_oe & m_out) |
      (~pins.oe & ~m_oe & flip);

   fic_host i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_spi_cs_n(cs_n), .o_spi_sck(sck),
      .o_io_pins(pins), .i_io_in(lvl));
   fic_flash_model #(.IDS(IDS), .UID(UID), .LOCK(3'h4), .ERASE_NS(20000))
      i_dev (.i_cs_n(cs_n), .i_sck(sck), .i_io(lvl), .o_out(m_out),
      .o_oe(m_oe), .o_err(m_err), .o_erases(m_erases), .o_polls(m_polls));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {1'h0, x[31:1]} ^ (x[0] ? 32'hA300_0000 : 32'h0);
   endfunction : lfsr

   // answer stream the device owes for each identification read
   function automatic logic [63:0] stream(input logic [7:0] op,
      input logic [23:0] a);
      logic [63:0] s;
      s = 64'h0;
      case (op)
         8'h90: s = {4{IDS[63:56], IDS[39:32]}};
         8'h92, 8'h94: s = a[0] ? {4{IDS[39:32], IDS[63:56]}} :
            {4{IDS[63:56], IDS[39:32]}};
         8'h4B: s = UID;
         8'h9F: s = IDS;
         8'h5A: for (int i = 0; i < 8; i++)
            s[63-8*i -: 8] = (a[7:0] + 8'(i)) ^ 8'hA5;
         default: s = 64'h0;
      endcase
      return s;
   endfunction : stream

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_sys_clk);
      i_wr <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_sys_clk);
      i_rd <= 1'h0;
      #1;
      d = o_rdata;
   endtask : rd

   // one instruction start to finish; status word of the last poll in st
   task automatic run(input logic [7:0] op, input logic [23:0] a,
      input int nb, input logic poll);
      wr(ADDR_OFS, {8'h0, a});
      wr(CTRL_OFS, {1'h1, 18'h0, poll, 4'(nb), op});
      st = 32'h0;
      for (int k = 0; k < 20000 && st[STAT_DONE_BIT] !== 1'h1; k++)
         rd(STAT_OFS, st);
      check(64'(st[STAT_DONE_BIT]), 64'h1);
      rd(RXLO_OFS, rx[31:0]);
      rd(RXHI_OFS, rx[63:32]);
   endtask : run

   task automatic id_case(input logic [7:0] op, input logic [23:0] a,
      input int nb);
      logic [63:0] m;
      m = (nb == 8) ? '1 : (64'h1 << (8 * nb)) - 64'h1;
      run(op, a, nb, 1'h0);
      check(rx & m, stream(op, a) >> (64 - 8 * nb));
   endtask : id_case

   task automatic report_and_stop();
      if (err_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   // watchdog: far beyond the few dozen frames of the run
   initial begin
      #5_000_000;
      err_count++;
      report_and_stop();
   end

   // fixed corner list: opcode and byte count per entry
   logic [7:0] ops [8] = '{8'h90, 8'h92, 8'h92, 8'h94,
      8'h94, 8'h9F, 8'h4B, 8'h5A};
   int nbs [8] = '{2, 2, 4, 2, 3, 3, 8, 4};

   initial begin
      logic [31:0] d;
      logic [23:0] a;
      int e;
      repeat (16) @(posedge i_sys_clk);
      i_rst_n <= 1'h1;
      // reset values, unmapped place reads zero and ignores writes
      rd(CTRL_OFS, d);
      check(d, 32'h0000_039F);
      rd(STAT_OFS, d);
      check(d, 32'h0);
      seed = lfsr(seed);
      wr(8'h14, seed);
      rd(8'h14, d);
      check(d, 32'h0);
      // fixed corner shapes first, then random repeats with random address
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         e = (i < 8) ? i : int'(seed[2:0]);
         a = seed[31:8];
         if (ops[e] == 8'h92 || ops[e] == 8'h94) begin
            a = (i < 8) ? 24'(e == 2 || e == 3) : 24'(seed[0]);
         end
         id_case(ops[e], a, nbs[e]);
      end
      // erase with the write latch clear is refused
      run(8'h44, 24'h002000 | seed[7:0], 0, 1'h1);
      check(m_erases, 0);
      check(st[9:8], 2'h0);
      run(8'h06, 24'h0, 0, 1'h0);
      run(8'h05, 24'h0, 1, 1'h0);
      check(rx[1:0], 2'h2);
      run(8'h44, 24'h002000 | seed[15:8], 0, 1'h1);
      check(m_erases, 1);
      check(st[9:8], 2'h0);
      check(m_polls > 0, 1);
      // locked register three: ignored, latch stays set
      run(8'h06, 24'h0, 0, 1'h0);
      run(8'h44, 24'h003000, 0, 1'h1);
      check(m_erases, 1);
      check(st[9:8], 2'h2);
      // stray bits beside the select field must not reach the wire
      run(8'h44, 24'hFF1F00 | seed[7:0], 0, 1'h1);
      check(m_erases, 2);
      check(m_err, 1'h0);
      report_and_stop();
   end
endmodule : fic_host_tb_top
`default_nettype wire
